// ### design/qts_pkg.sv
// Constants, field layout and types of the quick transfer submitter.
// Overview of operation
// - Plain parameter write stores, never launches.
// - Submit alias write stores and launches request.
// - No reload, no link; link bit reserved.
// - Hardware never alters stored parameters.
// - Whole frame or block; sync select ignored.
// - One request per submission, nothing intermediate.
// - Older variant write-only, newer variant readable.
// - Any write width rewrites whole register.
// - Writes stall while a request is pending.
// - Cache request wins the shared request node.
// - Urgent or reserved priority requests are discarded.
// - Quick request goes before simultaneous channel request.
// - Completion posts code to pending register, enable-gated.
// - Completion chaining gated by chain enable register.
// - Every register write takes one cycle.
// - Stores arrive as ordinary single-cycle memory writes.
// - Bit 15 reserved on older, extension on newer.
// - Request processing ignores any CPU debug halt.
package qts_pkg;

   // -------------------------------------------------------------------
   // Register indices (word addresses); bit 3 selects the submit alias
   // -------------------------------------------------------------------
   localparam logic [3:0] IDX_OPT = 4'h0;
   localparam logic [3:0] IDX_SRC = 4'h1;
   localparam logic [3:0] IDX_CNT = 4'h2;
   localparam logic [3:0] IDX_DST = 4'h3;
   localparam logic [3:0] IDX_IDX = 4'h4;
   localparam int SUBMIT_BIT = 3;
   localparam logic [2:0] SEL_LAST = 3'h4;

   // -------------------------------------------------------------------
   // Options field layout
   // -------------------------------------------------------------------
   localparam int PRI_HI = 31;
   localparam int PRI_LO = 29;
   localparam int SRC_2D_BIT = 26;
   localparam int DST_2D_BIT = 23;
   localparam int COMPLETION_INTERRUPT_ENABLE_BIT = 20;
   localparam int TCC_HI = 19;
   localparam int TCC_LO = 16;
   localparam int TCC_EXT_BIT = 15;
   localparam int ATCINT_BIT = 12;
   localparam int ATCC_HI = 9;
   localparam int ATCC_LO = 5;
   localparam int LINK_BIT = 1;
   localparam int FS_BIT = 0;

   // Write masks: link bit always reserved, bit 15 only on older variant
   localparam logic [31:0] OPT_MASK_OLD = 32'hffff7ffd;
   localparam logic [31:0] OPT_MASK_NEW = 32'hfffffffd;

   // -------------------------------------------------------------------
   // Reset values and priority limits
   // -------------------------------------------------------------------
   localparam logic [31:0] PARAM_RESET = 32'h00000000;
   // Edges the strap needs to cross both sync flops before capture
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [2:0] PRI_URGENT = 3'h0;
   localparam logic [2:0] PRI_MAX_OLD = 3'h2;
   localparam logic [2:0] PRI_MAX_NEW = 3'h3;

   typedef enum logic [1:0] {
      QTS_IDLE = 2'b00,
      QTS_PEND = 2'b01
   } qts_issue_state_t;

endpackage

// ### design/qts_cfg_if.sv
// Carrier between control, parameter bank and request issue unit.
`timescale 1ns/1ps
`default_nettype none
interface qts_cfg_if;
   logic wr_en;
   logic [2:0] wr_sel;
   logic [31:0] wr_data;
   logic newer;
   logic launch;
   logic pending;
   logic [31:0] opt;
   logic [31:0] src;
   logic [31:0] cnt;
   logic [31:0] dst;
   logic [31:0] idx;

   modport bank (input wr_en, input wr_sel, input wr_data, input newer,
      output opt, output src, output cnt, output dst, output idx);
   modport issue (input launch, input newer, input opt, output pending);
   modport ctrl (output wr_en, output wr_sel, output wr_data,
      output newer, output launch, input pending, input opt, input src,
      input cnt, input dst, input idx);
endinterface
`default_nettype wire

// ### design/qts_param_bank.sv
// Five quick transfer parameter registers.
`timescale 1ns/1ps
`default_nettype none
module qts_param_bank (
   input wire logic ref_clk,
   input wire logic rst,
   qts_cfg_if.bank cfg
);
   typedef struct packed {
      logic [31:0] opt;
      logic [31:0] src;
      logic [31:0] cnt;
      logic [31:0] dst;
      logic [31:0] idx;
   } qts_bank_t;

   qts_bank_t s_r;
   qts_bank_t s_nxt;
   logic [31:0] opt_mask;

   always_comb begin
      s_nxt = s_r;
      opt_mask = cfg.newer ? qts_pkg::OPT_MASK_NEW : qts_pkg::OPT_MASK_OLD;
      // Only software writes change these; no transfer touches them
      if (cfg.wr_en) begin
         case (cfg.wr_sel)
            qts_pkg::IDX_OPT[2:0]: begin
               s_nxt.opt = cfg.wr_data & opt_mask;
            end
            qts_pkg::IDX_SRC[2:0]: begin
               s_nxt.src = cfg.wr_data;
            end
            qts_pkg::IDX_CNT[2:0]: begin
               s_nxt.cnt = cfg.wr_data;
            end
            qts_pkg::IDX_DST[2:0]: begin
               s_nxt.dst = cfg.wr_data;
            end
            qts_pkg::IDX_IDX[2:0]: begin
               s_nxt.idx = cfg.wr_data;
            end
            default: begin
               s_nxt = s_r;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '{default: qts_pkg::PARAM_RESET};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cfg.opt = s_r.opt;
   assign cfg.src = s_r.src;
   assign cfg.cnt = s_r.cnt;
   assign cfg.dst = s_r.dst;
   assign cfg.idx = s_r.idx;
endmodule
`default_nettype wire

// ### design/qts_req_issue.sv
// Pending request tracking, priority check and node arbitration.
`timescale 1ns/1ps
`default_nettype none
module qts_req_issue (
   input wire logic ref_clk,
   input wire logic rst,
   qts_cfg_if.issue cfg,
   input wire logic cache_req,
   input wire logic tr_ready,
   output logic tr_valid,
   output logic tr_discard
);
   typedef struct packed {
      qts_pkg::qts_issue_state_t state;
      logic discard;
   } qts_issue_t;

   qts_issue_t s_r;
   qts_issue_t s_nxt;
   logic [2:0] priority_level_field;
   logic pri_ok;

   assign priority_level_field = cfg.opt[qts_pkg::PRI_HI:qts_pkg::PRI_LO];
   // Level 0 belongs to the cache; levels past the variant's top are void
   assign pri_ok = (priority_level_field != qts_pkg::PRI_URGENT) &&
      (priority_level_field <= (cfg.newer ? qts_pkg::PRI_MAX_NEW : qts_pkg::PRI_MAX_OLD));
   // Cache traffic on the shared node always goes first
   assign tr_valid = (s_r.state == qts_pkg::QTS_PEND) && pri_ok &&
      !cache_req;
   assign cfg.pending = (s_r.state == qts_pkg::QTS_PEND);
   assign tr_discard = s_r.discard;

   always_comb begin
      s_nxt = s_r;
      s_nxt.discard = 1'b0;
      // No debug halt input exists, so issue never freezes
      case (s_r.state)
         qts_pkg::QTS_IDLE: begin
            if (cfg.launch) begin
               s_nxt.state = qts_pkg::QTS_PEND;
            end
         end
         qts_pkg::QTS_PEND: begin
            if (!pri_ok) begin
               s_nxt.discard = 1'b1;
               s_nxt.state = qts_pkg::QTS_IDLE;
            end else if (tr_valid && tr_ready) begin
               s_nxt.state = qts_pkg::QTS_IDLE;
            end
         end
         default: begin
            s_nxt.state = qts_pkg::QTS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '{state: qts_pkg::QTS_IDLE, discard: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ### design/qts_top.sv
// Quick transfer submitter top: write path, reads, completion posting.
`timescale 1ns/1ps
`default_nettype none
module qts_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic variant_strap,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [3:0] wr_index,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_be,
   input wire logic rd_valid,
   input wire logic [3:0] rd_index,
   output logic [31:0] rd_data,
   output logic rd_ack,
   input wire logic cache_req,
   output logic chan_hold,
   output logic tr_valid,
   input wire logic tr_ready,
   output logic [31:0] tr_opt,
   output logic [31:0] tr_src,
   output logic [31:0] tr_cnt,
   output logic [31:0] tr_dst,
   output logic [31:0] tr_idx,
   output logic tr_whole_block,
   output logic tr_discard,
   input wire logic done_valid,
   input wire logic done_alt,
   input wire logic [31:0] done_opt,
   input wire logic [31:0] completion_enable_register,
   input wire logic [31:0] chain_enable_register,
   output logic [31:0] pend_set,
   output logic irq_req,
   output logic [31:0] chain_evt,
   output logic newer_variant
);
   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic strap_s1;
      logic strap_s2;
      logic caught;
      logic [1:0] settle;
      logic newer;
      logic [31:0] rd_data;
      logic rd_ack;
      logic [31:0] pend_set;
      logic irq;
      logic [31:0] chain;
   } qts_top_t;

   qts_top_t s_r;
   qts_top_t s_nxt;
   qts_cfg_if cfg ();

   logic wr_mapped;
   logic wr_take;
   logic rd_mapped;
   logic [31:0] rd_word;
   logic [4:0] code;
   logic [4:0] alt_code;
   logic [31:0] code_hot;
   logic [31:0] alt_hot;
   logic post_main;
   logic post_alt;
   logic [31:0] post_vec;

   // -------------------------------------------------------------------
   // Write path
   // -------------------------------------------------------------------
   // Byte enables are deliberately unused: every store is a full word
   // store, so narrow stores still rewrite the whole register.
   assign wr_mapped = (wr_index[2:0] <= qts_pkg::SEL_LAST);
   // Further stores hold off until the pending request leaves
   assign wr_ready = !cfg.pending;
   // One accepted store per cycle, straight into the bank
   assign wr_take = wr_valid && wr_ready && wr_mapped;

   assign cfg.wr_en = wr_take;
   assign cfg.wr_sel = wr_index[2:0];
   assign cfg.wr_data = wr_data;
   // Only the submit alias launches; it writes the bank too
   assign cfg.launch = wr_take && wr_index[qts_pkg::SUBMIT_BIT];
   assign cfg.newer = s_r.newer;

   // Channel side must wait whenever a quick request is about to go
   assign chan_hold = cfg.launch || cfg.pending;

   qts_param_bank u_bank (
      .ref_clk(ref_clk),
      .rst(rst),
      .cfg(cfg)
   );

   qts_req_issue u_issue (
      .ref_clk(ref_clk),
      .rst(rst),
      .cfg(cfg),
      .cache_req(cache_req),
      .tr_ready(tr_ready),
      .tr_valid(tr_valid),
      .tr_discard(tr_discard)
   );

   // -------------------------------------------------------------------
   // Request contents
   // -------------------------------------------------------------------
   // Bank is frozen while pending, so it drives the node directly
   assign tr_opt = cfg.opt;
   assign tr_src = cfg.src;
   assign tr_cnt = cfg.cnt;
   assign tr_dst = cfg.dst;
   assign tr_idx = cfg.idx;
   // 1-D to 1-D is one frame; anything 2-D is the whole block.
   // The frame sync bit plays no part here.
   assign tr_whole_block = cfg.opt[qts_pkg::SRC_2D_BIT] ||
      cfg.opt[qts_pkg::DST_2D_BIT];

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   assign rd_mapped = (rd_index[2:0] <= qts_pkg::SEL_LAST);

   always_comb begin
      case (rd_index[2:0])
         qts_pkg::IDX_OPT[2:0]: begin
            rd_word = cfg.opt;
         end
         qts_pkg::IDX_SRC[2:0]: begin
            rd_word = cfg.src;
         end
         qts_pkg::IDX_CNT[2:0]: begin
            rd_word = cfg.cnt;
         end
         qts_pkg::IDX_DST[2:0]: begin
            rd_word = cfg.dst;
         end
         qts_pkg::IDX_IDX[2:0]: begin
            rd_word = cfg.idx;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Completion posting and chaining
   // -------------------------------------------------------------------
   // Extension bit only counts on the newer variant
   assign code = {s_r.newer & done_opt[qts_pkg::TCC_EXT_BIT],
      done_opt[qts_pkg::TCC_HI:qts_pkg::TCC_LO]};
   assign alt_code = done_opt[qts_pkg::ATCC_HI:qts_pkg::ATCC_LO];
   assign code_hot = 32'h00000001 << code;
   assign alt_hot = 32'h00000001 << alt_code;
   assign post_main = done_valid && !done_alt &&
      done_opt[qts_pkg::COMPLETION_INTERRUPT_ENABLE_BIT];
   assign post_alt = done_valid && done_alt &&
      done_opt[qts_pkg::ATCINT_BIT];
   assign post_vec = (post_main ? code_hot : 32'h00000000) |
      (post_alt ? alt_hot : 32'h00000000);

   always_comb begin
      s_nxt = s_r;
      // Strap passes two flops, then is caught once after release.
      // Capture waits until the second flop holds the pin, otherwise
      // it would latch the reset value and always report older.
      // Stores made before the capture use the older write mask.
      s_nxt.strap_s1 = variant_strap;
      s_nxt.strap_s2 = s_r.strap_s1;
      if (s_r.settle != qts_pkg::STRAP_SETTLE) begin
         s_nxt.settle = s_r.settle + 2'h1;
      end else if (!s_r.caught) begin
         s_nxt.newer = s_r.strap_s2;
         s_nxt.caught = 1'b1;
      end
      // Older variant is write-only; its reads return zero
      s_nxt.rd_ack = rd_valid;
      s_nxt.rd_data = 32'h00000000;
      if (rd_valid && rd_mapped && s_r.newer) begin
         s_nxt.rd_data = rd_word;
      end
      s_nxt.pend_set = post_vec;
      s_nxt.irq = |(post_vec & completion_enable_register);
      s_nxt.chain = post_vec & chain_enable_register;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data = s_r.rd_data;
   assign rd_ack = s_r.rd_ack;
   assign pend_set = s_r.pend_set;
   assign irq_req = s_r.irq;
   assign chain_evt = s_r.chain;
   assign newer_variant = s_r.newer;
endmodule
`default_nettype wire

// ### testbench/qts_monitor.sv
// Port assertions for the quick transfer submitter.
`timescale 1ns/1ps
`default_nettype none
module qts_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [3:0] wr_index,
   input wire logic [31:0] wr_data,
   input wire logic cache_req,
   input wire logic chan_hold,
   input wire logic tr_valid,
   input wire logic tr_ready,
   input wire logic [31:0] tr_opt,
   input wire logic [31:0] tr_src,
   input wire logic tr_whole_block,
   input wire logic [31:0] pend_set,
   input wire logic [31:0] completion_enable_register,
   input wire logic irq_req,
   input wire logic newer_variant
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_submit;
      wr_valid && wr_ready && wr_index[3] && wr_index[2:0] <= 3'h4;
   endsequence
   sequence s_legal_submit;
      s_submit ##0 (wr_index[2:0] == 3'h0 && wr_data[31:29] == 3'h1);
   endsequence

   property p_submit_stall;
      s_submit |=> !wr_ready;
   endproperty
   a_submit_stall: assert property (p_submit_stall)
      else $error("writes not stalled after submit");
   property p_plain_idle;
      wr_valid && wr_ready && !wr_index[3] |=> wr_ready && !tr_valid;
   endproperty
   a_plain_idle: assert property (p_plain_idle)
      else $error("plain write launched a request");
   property p_issue;
      s_legal_submit |-> ##[1:20] tr_valid;
   endproperty
   a_issue: assert property (p_issue)
      else $error("submit did not raise a request");
   property p_cache_wins;
      cache_req |-> !tr_valid;
   endproperty
   a_cache_wins: assert property (p_cache_wins)
      else $error("request offered against cache traffic");
   property p_send_frees;
      tr_valid && tr_ready |=> wr_ready;
   endproperty
   a_send_frees: assert property (p_send_frees)
      else $error("stall kept after request sent");
   property p_hold_params;
      !wr_ready |=> $stable(tr_opt) && $stable(tr_src);
   endproperty
   a_hold_params: assert property (p_hold_params)
      else $error("parameters changed while pending");
   property p_whole_block;
      tr_valid |-> tr_whole_block == (tr_opt[26] | tr_opt[23]);
   endproperty
   a_whole_block: assert property (p_whole_block)
      else $error("frame or block size wrong");
   property p_legal_pri;
      tr_valid |-> tr_opt[31:29] != 3'h0 &&
         tr_opt[31:29] <= (newer_variant ? 3'h3 : 3'h2);
   endproperty
   a_legal_pri: assert property (p_legal_pri)
      else $error("illegal priority request offered");
   property p_quick_first;
      s_submit |-> chan_hold;
   endproperty
   a_quick_first: assert property (p_quick_first)
      else $error("channel not held on submit");
   property p_irq_gate;
      irq_req == |(pend_set & completion_enable_register);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not gated by enables");
endmodule

bind qts_top qts_monitor mon (.ref_clk, .rst, .wr_valid, .wr_ready,
   .wr_index, .wr_data, .cache_req, .chan_hold, .tr_valid, .tr_ready,
   .tr_opt, .tr_src, .tr_whole_block, .pend_set, .completion_enable_register, .irq_req,
   .newer_variant);
`default_nettype wire

// ### testbench/qts_node_model.sv
// Transfer request node stand-in with a cache contention window.
`timescale 1ns/1ps
`default_nettype none
module qts_node_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tr_valid,
   input wire logic submit,
   input wire logic [3:0] cache_len,
   output logic tr_ready,
   output logic cache_req
);
   logic [3:0] busy_r;

   // Cache traffic takes the node for cache_len cycles after a submit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         busy_r <= 4'h0;
      else if (submit)
         busy_r <= cache_len;
      else if (busy_r != 4'h0)
         busy_r <= busy_r - 4'h1;
   end

   assign cache_req = (busy_r != 4'h0);
   // Accepts on the first free cycle; slowness comes only from the cache
   assign tr_ready = tr_valid & !cache_req;
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Directed bench for the quick transfer submitter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk, rst, variant_strap, wr_valid, wr_ready, rd_valid;
   logic rd_ack, cache_req, chan_hold, tr_valid, tr_ready, irq_req;
   logic tr_whole_block, tr_discard, done_valid, done_alt, newer_variant;
   logic [3:0] wr_index, wr_be, rd_index, cache_len;
   logic [31:0] wr_data, rd_data, tr_opt, tr_src, tr_cnt, tr_dst, tr_idx;
   logic [31:0] done_opt, completion_enable_register, chain_enable_register, pend_set, chain_evt;
   logic [2:0] bad [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   int fail_count, samples_checked, cycles, n;

   qts_top dut (.ref_clk, .rst, .variant_strap, .wr_valid, .wr_ready,
      .wr_index, .wr_data, .wr_be, .rd_valid, .rd_index, .rd_data, .rd_ack,
      .cache_req, .chan_hold, .tr_valid, .tr_ready, .tr_opt, .tr_src,
      .tr_cnt, .tr_dst, .tr_idx, .tr_whole_block, .tr_discard, .done_valid,
      .done_alt, .done_opt, .completion_enable_register, .chain_enable_register, .pend_set, .irq_req, .chain_evt,
      .newer_variant);
   qts_node_model node (.ref_clk, .rst, .tr_valid,
      .submit(wr_valid & wr_ready & wr_index[3]), .cache_len, .tr_ready,
      .cache_req);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Counts stalled cycles in n; the store is held until taken or 40 stalled cycles pass
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      @(posedge ref_clk);
      wr_valid <= 1'b1;
      wr_index <= i;
      wr_data <= d;
      n = 0;
      @(negedge ref_clk);
      while (wr_ready !== 1'b1 && n < 40) begin
         n++;
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
      wr_valid <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] i, input logic [31:0] exp);
      @(posedge ref_clk);
      rd_valid <= 1'b1;
      rd_index <= i;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
      @(negedge ref_clk);
      chk({31'h0, rd_ack}, 32'h1);
      chk(rd_data, exp);
   endtask

   task automatic done(input logic alt, input logic [31:0] o,
      input logic [31:0] exp);
      @(posedge ref_clk);
      done_valid <= 1'b1;
      done_alt <= alt;
      done_opt <= o;
      @(posedge ref_clk);
      done_valid <= 1'b0;
      @(negedge ref_clk);
      chk(pend_set, exp);
      chk(chain_evt, exp & chain_enable_register);
      chk({31'h0, irq_req}, {31'h0, |(exp & completion_enable_register)});
   endtask

   initial begin
      rst = 1'b1;
      variant_strap = 1'b0;
      wr_valid = 1'b0;
      wr_index = 4'h0;
      wr_data = 32'h0;
      wr_be = 4'hf;
      rd_valid = 1'b0;
      rd_index = 4'h0;
      done_valid = 1'b0;
      done_alt = 1'b0;
      done_opt = 32'h0;
      completion_enable_register = 32'h0000ff00;
      chain_enable_register = 32'h00020000;
      cache_len = 4'h0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk(tr_opt | tr_src | tr_cnt | tr_dst | tr_idx, 32'h0);
      wr(4'h1, 32'h80001000);
      wr_be <= 4'h1;
      wr(4'h2, 32'h00030010);
      wr(4'h3, 32'h80002000);
      wr(4'h4, 32'h00400004);
      @(negedge ref_clk);
      chk(tr_cnt, 32'h00030010);
      chk(tr_idx, 32'h00400004);
      chk({31'h0, tr_valid}, 32'h0);
      // Link bit and bit 15 are dropped, sync select kept but ignored
      wr(4'h8, 32'h21b88003);
      @(negedge ref_clk);
      chk({31'h0, tr_valid}, 32'h1);
      chk(tr_dst, 32'h80002000);
      chk(tr_opt, 32'h21b80001);
      chk({31'h0, tr_whole_block}, 32'h1);
      chk(tr_src, 32'h80001000);
      wr(4'h8, 32'h40000000);
      @(negedge ref_clk);
      chk({31'h0, tr_whole_block}, 32'h0);
      for (int k = 1; k < 6; k += 2) begin
         cache_len <= 4'(k);
         wr(4'h9, 32'h100 + 32'(k));
         wr(4'h3, 32'h0);
         chk(32'(n), 32'(k));
         chk(tr_src, 32'h100 + 32'(k));
      end
      foreach (bad[j]) begin
         wr(4'h8, {bad[j], 29'h0});
         @(negedge ref_clk);
         chk({30'h0, tr_discard, tr_valid}, 32'h0);
         // Drop pulse follows the single pending cycle
         @(negedge ref_clk);
         chk({30'h0, tr_discard, tr_valid}, 32'h2);
      end
      rd(4'h1, 32'h0);
      rd(4'h6, 32'h0);
      chk({31'h0, newer_variant}, 32'h0);
      done(1'b0, 32'h001f8000, 32'h00008000);
      done(1'b1, 32'h00001220, 32'h00020000);
      done(1'b0, 32'h000f0000, 32'h0);
      // Second reset with the strap high selects the newer variant
      @(posedge ref_clk);
      cache_len <= 4'h0;
      variant_strap <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({31'h0, newer_variant}, 32'h1);
      wr(4'h8, 32'h60008003);
      @(negedge ref_clk);
      chk({31'h0, tr_valid}, 32'h1);
      chk(tr_opt, 32'h60008001);
      rd(4'h0, 32'h60008001);
      rd(4'h8, 32'h60008001);
      done(1'b0, 32'h001f8000, 32'h80000000);
      final_report();
   end
endmodule
`default_nettype wire
